// ### rtl/nsp_pkg.sv
// Constants, register layouts and types of the NAND register bank.
package nsp_pkg;

    localparam logic [7:0] OPC_RD_FEAT_A  = 8'h0F;
    localparam logic [7:0] OPC_RD_FEAT_B  = 8'h05;
    localparam logic [7:0] OPC_WR_FEAT_A  = 8'h1F;
    localparam logic [7:0] OPC_WR_FEAT_B  = 8'h01;
    localparam logic [7:0] OPC_WRITE_ENABLE_CMD       = 8'h06;
    localparam logic [7:0] OPC_WRDI       = 8'h04;
    localparam logic [7:0] OPC_RESET      = 8'hFF;
    localparam logic [7:0] OPC_PROG_EXEC  = 8'h10;
    localparam logic [7:0] OPC_ERASE      = 8'hD8;
    localparam logic [7:0] OPC_PAGE_READ  = 8'h13;
    localparam logic [7:0] OPC_BBM        = 8'hA1;
    localparam logic [7:0] OPC_READ_ID    = 8'h9F;
    localparam logic [7:0] OPC_OTP_LOCK   = 8'h1F;

    localparam logic [7:0] ADDR_PROT      = 8'hA0;
    localparam logic [7:0] ADDR_CFG       = 8'hB0;
    localparam logic [7:0] ADDR_FLAGS     = 8'hC0;

    typedef struct packed {
        logic       reg_protect_low;
        logic [3:0] block_protect;
        logic       top_bottom_select;
        logic       wp_enable;
        logic       reg_protect_high;
    } nsp_prot_t;

    typedef struct packed {
        logic       otp_lock;
        logic       otp_enter;
        logic       rsvd5;
        logic       ecc_enable;
        logic [3:0] rsvd3_0;
    } nsp_cfg_t;

    typedef struct packed {
        logic       rsvd7;
        logic       link_table_full;
        logic [1:0] ecc_status;
        logic       prog_fail;
        logic       erase_fail;
        logic       write_enable_latch;
        logic       busy;
    } nsp_flags_t;

    typedef enum logic [2:0] {OPK_NONE, OPK_READ, OPK_PROG, OPK_ERASE, OPK_BBM, OPK_LOCK} nsp_op_t;

    localparam nsp_prot_t PROT_RST = 8'h7C;
    localparam nsp_cfg_t  CFG_RST  = 8'h10;
    localparam logic [7:0] CFG_WR_MASK = 8'hD0;

    localparam logic [1:0] ECC_OK_0_3    = 2'h0;
    localparam logic [1:0] ECC_OK_4      = 2'h1;
    localparam logic [1:0] ECC_UNCORRECT = 2'h2;

    localparam int LINK_MAX      = 20;
    localparam int NUM_BLK_BITS  = 12;
    localparam int ROW_BLK_LSB   = 6;
    localparam int BP_BASE_SPAN  = 8;
    localparam logic [3:0] BP_ALL_CODE = 4'hA;

    localparam logic [2:0] BYTE_DATA   = 3'h2;
    localparam logic [2:0] BYTE_ROW_END = 3'h4;
    localparam logic [2:0] BYTE_BBM_END = 3'h5;

    localparam logic [3:0] PIN_SYNC_RST = 4'h5;

    localparam int CLK_FREQ_MHZ  = 10;
    localparam int PWRUP_TIME_US = 1000;
    localparam int PWRUP_CYCLES  = PWRUP_TIME_US * CLK_FREQ_MHZ;

endpackage : nsp_pkg

// ### rtl/nsp_sync.sv
// Two-stage synchroniser for pin levels.
module nsp_sync
    import nsp_pkg::*;
#(
    parameter int              W       = 4,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [W-1:0]  d,
    output logic      [W-1:0]  q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // nsp_sync

// ### rtl/nsp_bp_decode.sv
// Decoder of the block-protect code into a protected flag for one block.
module nsp_bp_decode
    import nsp_pkg::*;
#(
    parameter int BLK_W = NUM_BLK_BITS
) (
    input  wire logic [3:0]       bp,
    input  wire logic             tb,
    input  wire logic [BLK_W-1:0] block,
    output logic                  prot
);
    logic [BLK_W:0] span;
    logic [BLK_W:0] top_base;
    logic [BLK_W:0] blk_ext;

    always_comb begin
        span     = '0;
        top_base = '0;
        blk_ext  = {1'b0, block};
        prot     = 1'b0;
        if (bp >= BP_ALL_CODE) begin
            prot = 1'b1;
        end else if (bp != 4'h0) begin
            span     = (BLK_W+1)'(BP_BASE_SPAN) << (bp - 4'h1);
            top_base = (BLK_W+1)'(1 << BLK_W) - span;
            prot     = tb ? (blk_ext < span) : (blk_ext >= top_base);
        end
    end
endmodule // nsp_bp_decode

// ### rtl/nsp_regs.sv
// Serial register bank with write protection, configuration and status flags.
module nsp_regs
    import nsp_pkg::*;
#(
    parameter int PWRUP_CNT = PWRUP_CYCLES,
    parameter int LINKS     = LINK_MAX
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        SCLK,
    input  wire logic        CS_N,
    input  wire logic        DI,
    input  wire logic        WP_N,
    output logic             DO_O,
    output logic             DO_OE,
    input  wire logic        OP_DONE,
    input  wire logic        OP_FAIL,
    input  wire logic        ECC_VALID,
    input  wire logic [1:0]  ECC_RESULT,
    output logic             OP_START,
    output logic [7:0]       OP_CMD,
    output logic [23:0]      OP_ROW,
    output logic             ECC_ENABLE,
    output logic             OTP_ACCESS,
    output logic             OTP_LOCKED,
    output logic             QUAD_ALLOWED
);
    localparam int PC_W = $clog2(PWRUP_CNT + 1);
    localparam int LC_W = $clog2(LINKS + 1);

    logic [3:0]      pins;
    logic            s_sclk;
    logic            s_cs_n;
    logic            s_di;
    logic            s_wp_n;
    logic            sclk_prev_q;
    logic            cs_prev_q;
    logic            rise;
    logic            fall;
    logic            cs_end;
    logic [2:0]      bit_cnt_q;
    logic [2:0]      byte_cnt_q;
    logic [6:0]      shift_q;
    logic [7:0]      new_byte;
    logic            byte_done;
    logic [7:0]      opcode_q;
    logic [7:0]      addr_q;
    logic [23:0]     row_q;
    logic            ignore_q;
    nsp_prot_t       prot_q;
    nsp_cfg_t        cfg_q;
    logic            wel_q;
    logic            prog_fail_q;
    logic            erase_fail_q;
    logic [1:0]      ecc_status_q;
    logic [LC_W-1:0] link_cnt_q;
    logic            link_full;
    logic            pwrup_q;
    logic [PC_W-1:0] pwrup_cnt_q;
    logic            op_active_q;
    nsp_op_t         op_kind_q;
    logic            busy;
    logic            blk_prot;
    logic            hw_block;
    logic            prot_lock;
    logic            wr_req;
    logic            wr_ok;
    logic            exec;
    logic            prog_go;
    logic            erase_go;
    logic            read_go;
    logic            bbm_go;
    logic            lock_go;
    logic            prog_bad;
    logic            erase_bad;
    nsp_flags_t      flags;
    logic [7:0]      rd_byte;

    function automatic logic is_op(input logic [7:0] op, input logic [7:0] a,
                                   input logic [7:0] b);
        return (op == a) || (op == b);
    endfunction

    function automatic logic [7:0] read_reg(input logic [7:0] a, input nsp_prot_t p,
                                            input nsp_cfg_t c, input nsp_flags_t f);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ADDR_PROT:  v = p;
            ADDR_CFG:   v = c & CFG_WR_MASK;
            ADDR_FLAGS: v = f;
            default:    v = 8'h00;
        endcase
        return v;
    endfunction

    nsp_sync #(
        .W       (4),
        .RST_VAL (PIN_SYNC_RST)
    ) u_sync (
        .clk   (CLK),
        .rst_n (RST_N),
        .d     ({SCLK, CS_N, DI, WP_N}),
        .q     (pins)
    );

    assign s_sclk = pins[3];
    assign s_cs_n = pins[2];
    assign s_di   = pins[1];
    assign s_wp_n = pins[0];

    nsp_bp_decode #(
        .BLK_W (NUM_BLK_BITS)
    ) u_bp (
        .bp    (prot_q.block_protect),
        .tb    (prot_q.top_bottom_select),
        .block (row_q[ROW_BLK_LSB +: NUM_BLK_BITS]),
        .prot  (blk_prot)
    );

    // Edge detection of the link clock and chip select.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q   <= 1'b1;
        end else begin
            sclk_prev_q <= s_sclk;
            cs_prev_q   <= s_cs_n;
        end
    end

    assign rise      = s_sclk & ~sclk_prev_q & ~s_cs_n;
    assign fall      = ~s_sclk & sclk_prev_q & ~s_cs_n;
    assign cs_end    = s_cs_n & ~cs_prev_q;
    assign byte_done = rise && (bit_cnt_q == 3'h7);
    assign new_byte  = {shift_q, s_di};

    // Bit and byte counters of the current frame.
    always_ff @(posedge CLK) begin
        if (!RST_N || s_cs_n) begin
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 3'h0;
            shift_q    <= 7'h00;
        end else if (rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q   <= new_byte[6:0];
            if (byte_done && byte_cnt_q != 3'h7) begin
                byte_cnt_q <= byte_cnt_q + 3'h1;
            end
        end
    end

    // Opcode, register address and row address capture.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            opcode_q <= 8'h00;
            addr_q   <= 8'h00;
            row_q    <= 24'h000000;
            ignore_q <= 1'b0;
        end else if (byte_done) begin
            if (byte_cnt_q == 3'h0) begin
                opcode_q <= new_byte;
                ignore_q <= busy && !is_op(new_byte, OPC_RD_FEAT_A, OPC_RD_FEAT_B)
                            && (new_byte != OPC_READ_ID);
            end
            if (byte_cnt_q == 3'h1) begin
                addr_q <= new_byte;
            end
            row_q <= {row_q[15:0], new_byte};
        end
    end

    assign busy      = pwrup_q | op_active_q;
    assign link_full = (link_cnt_q == LC_W'(LINKS));
    assign hw_block  = prot_q.wp_enable & ~s_wp_n;
    assign prot_lock = prot_q.reg_protect_high | (prot_q.reg_protect_low & ~s_wp_n);
    assign exec      = cs_end & ~ignore_q;

    assign wr_req = byte_done && (byte_cnt_q == BYTE_DATA) && !ignore_q
                    && is_op(opcode_q, OPC_WR_FEAT_A, OPC_WR_FEAT_B);
    assign wr_ok  = wel_q && !hw_block;

    assign prog_go  = exec && opcode_q == OPC_PROG_EXEC && byte_cnt_q >= BYTE_ROW_END && wel_q;
    assign erase_go = exec && opcode_q == OPC_ERASE && byte_cnt_q >= BYTE_ROW_END && wel_q;
    assign read_go  = exec && opcode_q == OPC_PAGE_READ && byte_cnt_q >= BYTE_ROW_END;
    assign bbm_go   = exec && opcode_q == OPC_BBM && byte_cnt_q >= BYTE_BBM_END && wel_q
                      && !link_full && !hw_block;
    assign lock_go  = wr_req && wr_ok && addr_q == ADDR_CFG && new_byte[7] && !cfg_q.otp_lock;

    assign prog_bad  = hw_block | (cfg_q.otp_enter ? cfg_q.otp_lock : blk_prot);
    assign erase_bad = hw_block | cfg_q.otp_enter | blk_prot;

    // Protection register writes; refused writes change nothing.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            prot_q <= PROT_RST;
        end else if (wr_req && wr_ok && addr_q == ADDR_PROT && !prot_lock) begin
            prot_q <= new_byte;
        end
    end

    // Configuration register writes and the one-time lock.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cfg_q <= CFG_RST;
        end else if (wr_req && wr_ok && addr_q == ADDR_CFG) begin
            cfg_q.otp_lock   <= cfg_q.otp_lock | new_byte[7];
            cfg_q.otp_enter  <= new_byte[6];
            cfg_q.ecc_enable <= new_byte[4];
        end else if (exec && opcode_q == OPC_RESET) begin
            cfg_q.otp_enter <= 1'b0;
        end
    end

    // Write-enable latch.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wel_q <= 1'b0;
        end else if (exec && opcode_q == OPC_WRITE_ENABLE_CMD) begin
            wel_q <= 1'b1;
        end else if (exec && (opcode_q == OPC_WRDI || opcode_q == OPC_PROG_EXEC
                     || opcode_q == OPC_ERASE || opcode_q == OPC_PAGE_READ
                     || (opcode_q == OPC_BBM && cfg_q.otp_enter))) begin
            wel_q <= 1'b0;
        end
    end

    // Program and erase failure flags; a set in the same cycle wins.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            prog_fail_q  <= 1'b0;
            erase_fail_q <= 1'b0;
        end else begin
            if ((exec && opcode_q == OPC_RESET) || prog_go || erase_go) begin
                prog_fail_q  <= 1'b0;
                erase_fail_q <= 1'b0;
            end
            if ((prog_go && prog_bad) || (OP_DONE && OP_FAIL && op_kind_q == OPK_PROG)) begin
                prog_fail_q <= 1'b1;
            end
            if ((erase_go && erase_bad) || (OP_DONE && OP_FAIL && op_kind_q == OPK_ERASE)) begin
                erase_fail_q <= 1'b1;
            end
        end
    end

    // ECC result field.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ecc_status_q <= ECC_OK_0_3;
        end else if (ECC_VALID && op_kind_q == OPK_READ) begin
            ecc_status_q <= ECC_RESULT;
        end else if (exec && opcode_q == OPC_RESET) begin
            ecc_status_q <= ECC_OK_0_3;
        end
    end

    // Count of established bad-block links.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            link_cnt_q <= '0;
        end else if (OP_DONE && !OP_FAIL && op_kind_q == OPK_BBM && !link_full) begin
            link_cnt_q <= link_cnt_q + LC_W'(1);
        end
    end

    // Power-up busy interval.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pwrup_q     <= 1'b1;
            pwrup_cnt_q <= PC_W'(PWRUP_CNT - 1);
        end else if (pwrup_q) begin
            pwrup_cnt_q <= pwrup_cnt_q - PC_W'(1);
            if (pwrup_cnt_q == '0) begin
                pwrup_q <= 1'b0;
            end
        end
    end

    // Internal operation start and completion.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            op_active_q <= 1'b0;
            op_kind_q   <= OPK_NONE;
            OP_START    <= 1'b0;
            OP_CMD      <= 8'h00;
            OP_ROW      <= 24'h000000;
        end else begin
            OP_START <= 1'b0;
            if ((prog_go && !prog_bad) || (erase_go && !erase_bad) || read_go || bbm_go
                || lock_go) begin
                op_active_q <= 1'b1;
                OP_START    <= 1'b1;
                OP_CMD      <= lock_go ? OPC_OTP_LOCK : opcode_q;
                OP_ROW      <= row_q;
                op_kind_q   <= lock_go ? OPK_LOCK : prog_go ? OPK_PROG : erase_go ? OPK_ERASE
                               : read_go ? OPK_READ : OPK_BBM;
            end else if (op_active_q && OP_DONE) begin
                op_active_q <= 1'b0;
            end
        end
    end

    always_comb begin
        flags                    = '0;
        flags.link_table_full    = link_full;
        flags.ecc_status         = ecc_status_q;
        flags.prog_fail          = prog_fail_q;
        flags.erase_fail         = erase_fail_q;
        flags.write_enable_latch = wel_q;
        flags.busy               = busy;
    end

    assign rd_byte = read_reg(addr_q, prot_q, cfg_q, flags);

    // Serial read-out of the addressed register, MSB first on falling edges.
    always_ff @(posedge CLK) begin
        if (!RST_N || s_cs_n) begin
            DO_O  <= 1'b0;
            DO_OE <= 1'b0;
        end else if (fall && byte_cnt_q >= BYTE_DATA
                     && is_op(opcode_q, OPC_RD_FEAT_A, OPC_RD_FEAT_B)) begin
            DO_O  <= rd_byte[3'h7 - bit_cnt_q];
            DO_OE <= 1'b1;
        end
    end

    // Mode outputs toward the array and pin logic.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ECC_ENABLE   <= CFG_RST.ecc_enable;
            OTP_ACCESS   <= 1'b0;
            OTP_LOCKED   <= 1'b0;
            QUAD_ALLOWED <= ~PROT_RST.wp_enable;
        end else begin
            ECC_ENABLE   <= cfg_q.ecc_enable;
            OTP_ACCESS   <= cfg_q.otp_enter;
            OTP_LOCKED   <= cfg_q.otp_lock;
            QUAD_ALLOWED <= ~prot_q.wp_enable;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    chk_wel_set: assert property (exec && opcode_q == OPC_WRITE_ENABLE_CMD |=> wel_q)
        else $error("latch not set by write enable");
    chk_wel_clear: assert property (exec && (opcode_q == OPC_PROG_EXEC
        || opcode_q == OPC_ERASE) |=> !wel_q)
        else $error("latch not cleared after program or erase");
    chk_prot_locked: assert property (wr_req && prot_lock && addr_q == ADDR_PROT
        |=> $stable(prot_q))
        else $error("locked protection register changed");
    chk_hw_block: assert property (hw_block && exec && !lock_go
        && opcode_q != OPC_PAGE_READ |=> !OP_START)
        else $error("operation started while write protect pin low");
    chk_busy_ignore: assert property (busy && byte_done && byte_cnt_q == 3'h0
        && new_byte == OPC_WRITE_ENABLE_CMD |=> ignore_q)
        else $error("command taken while busy");
    chk_busy_clear: assert property (op_active_q && OP_DONE && !OP_START
        |=> !op_active_q ##1 !op_active_q || OP_START)
        else $error("busy not cleared on completion");
    chk_ecc_keep: assert property (exec && opcode_q == OPC_RESET && !wr_req
        |=> $stable(cfg_q.ecc_enable) && ecc_status_q == ECC_OK_0_3)
        else $error("reset command disturbed ecc state");
    chk_fail_prot: assert property (prog_go && prog_bad |=> prog_fail_q && !OP_START)
        else $error("protected program not flagged");
    chk_lut_full: assert property (link_full && exec && opcode_q == OPC_BBM |=> !OP_START)
        else $error("link created with full table");
    chk_quad_mode: assert property (##1 QUAD_ALLOWED == $past(~prot_q.wp_enable))
        else $error("quad permission does not follow protect mode");
    chk_reset_vals: assert property (@(posedge CLK) disable iff (1'b0)
        !RST_N |=> prot_q == PROT_RST && busy && !wel_q && cfg_q.ecc_enable)
        else $error("wrong register values after power-up");

    cov_prot_write: cover property (wr_req && wr_ok && addr_q == ADDR_PROT && !prot_lock);
    cov_prog_start: cover property (prog_go && !prog_bad ##[1:3] OP_START);
    cov_bbm_start: cover property (bbm_go ##1 OP_START);
    cov_status_read: cover property (DO_OE && opcode_q == OPC_RD_FEAT_A && addr_q == ADDR_FLAGS);

endmodule // nsp_regs

// ### tb/nsp_host.sv
// Host model that drives the serial register link and answers array operations.
module nsp_host
    import nsp_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       DO_O,
    input  wire logic       DO_OE,
    input  wire logic       OP_START,
    input  wire logic       fail_mode,
    input  wire logic [1:0] ecc_val,
    output logic            SCLK,
    output logic            CS_N,
    output logic            DI,
    output logic            OP_DONE,
    output logic            OP_FAIL,
    output logic            ECC_VALID,
    output logic [1:0]      ECC_RESULT
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        DI = 1'b0;
        OP_DONE = 1'b0;
        ECC_VALID = 1'b0;
    end
    assign OP_FAIL = fail_mode;
    assign ECC_RESULT = ecc_val;
    // The array engine finishes each started operation after a fixed delay.
    always @(posedge CLK) begin
        OP_DONE <= (cnt == 1);
        ECC_VALID <= (cnt == 1);
        cnt <= OP_START ? 50 : (cnt != 0 ? cnt - 1 : 0);
    end
    // One frame, bytes MSB first; the clock stands still outside frames.
    task automatic xfer(input logic [7:0] b[$], output logic [7:0] rx);
        @(posedge CLK);
        CS_N <= 1'b0;
        foreach (b[i]) begin
            for (int j = 7; j >= 0; j--) begin
                repeat (4) @(posedge CLK);
                SCLK <= 1'b0;
                DI <= b[i][j];
                repeat (4) @(posedge CLK);
                SCLK <= 1'b1;
                rx = {rx[6:0], DO_OE ? DO_O : 1'bx};
            end
        end
        repeat (4) @(posedge CLK);
        SCLK <= 1'b0;
        DI <= ~DI;
        repeat (4) @(posedge CLK);
        CS_N <= 1'b1;
        repeat (8) @(posedge CLK);
    endtask
endmodule // nsp_host

// ### tb/nsp_regs_tb.sv
// Self-checking testbench of the serial register bank.
module nsp_regs_tb;
    import nsp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        CLK, RST_N, WP_N, fail_mode, SCLK, CS_N, DI, DO_O, DO_OE;
    logic        OP_DONE, OP_FAIL, ECC_VALID, OP_START, ECC_ENABLE;
    logic        OTP_ACCESS, OTP_LOCKED, QUAD_ALLOWED;
    logic [1:0]  ecc_val, ECC_RESULT;
    logic [7:0]  OP_CMD, rx;
    logic [7:0]  n_start = 8'h00;
    logic [23:0] OP_ROW;
    int          n_mismatch = 0;
    int          checks_done = 0;
    nsp_regs #(.PWRUP_CNT(400), .LINKS(3)) uut (
        .CLK(CLK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N), .DI(DI), .WP_N(WP_N),
        .DO_O(DO_O), .DO_OE(DO_OE), .OP_DONE(OP_DONE), .OP_FAIL(OP_FAIL),
        .ECC_VALID(ECC_VALID), .ECC_RESULT(ECC_RESULT), .OP_START(OP_START),
        .OP_CMD(OP_CMD), .OP_ROW(OP_ROW), .ECC_ENABLE(ECC_ENABLE),
        .OTP_ACCESS(OTP_ACCESS), .OTP_LOCKED(OTP_LOCKED), .QUAD_ALLOWED(QUAD_ALLOWED));
    nsp_host host (
        .CLK(CLK), .DO_O(DO_O), .DO_OE(DO_OE), .OP_START(OP_START),
        .fail_mode(fail_mode), .ecc_val(ecc_val), .SCLK(SCLK), .CS_N(CS_N), .DI(DI),
        .OP_DONE(OP_DONE), .OP_FAIL(OP_FAIL), .ECC_VALID(ECC_VALID),
        .ECC_RESULT(ECC_RESULT));
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        if (OP_START === 1'b1) n_start <= n_start + 8'h01;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op);
        host.xfer({op}, rx);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer({OPC_WR_FEAT_A, a, d}, rx);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        host.xfer({OPC_RD_FEAT_A, a, 8'h00}, rx);
        chk(rx, exp);
    endtask
    task automatic ready();
        for (int k = 0; k < 20; k++) begin
            host.xfer({OPC_RD_FEAT_A, ADDR_FLAGS, 8'h00}, rx);
            if (rx[0] === 1'b0) break;
        end
    endtask
    task automatic op4(input logic [7:0] op, input logic [23:0] row);
        cmd(OPC_WRITE_ENABLE_CMD);
        host.xfer({op, row[23:16], row[15:8], row[7:0]}, rx);
        ready();
    endtask
    task automatic por();
        RST_N <= 1'b0;
        repeat (10) @(posedge CLK);
        RST_N <= 1'b1;
        repeat (2) @(posedge CLK);
    endtask
    task automatic conclude();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        n_mismatch++;
        conclude();
    end
    initial begin
        RST_N = 1'b0;
        WP_N = 1'b1;
        fail_mode = 1'b0;
        ecc_val = 2'h0;
        repeat (10) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        rd(ADDR_FLAGS, 8'h01);
        ready();
        host.xfer({OPC_RD_FEAT_B, ADDR_PROT, 8'h00}, rx);
        chk(rx, 8'h7C);
        rd(ADDR_CFG, 8'h10);
        rd(ADDR_FLAGS, 8'h00);
        chk({7'h00, QUAD_ALLOWED}, 8'h01);
        $display("test power-up done");
        wr(ADDR_PROT, 8'h00);
        rd(ADDR_PROT, 8'h7C);
        cmd(OPC_WRITE_ENABLE_CMD);
        rd(ADDR_FLAGS, 8'h02);
        wr(ADDR_CFG, 8'h00);
        rd(ADDR_CFG, 8'h00);
        chk({7'h00, ECC_ENABLE}, 8'h00);
        wr(ADDR_CFG, 8'h10);
        wr(ADDR_PROT, 8'h80);
        WP_N <= 1'b0;
        wr(ADDR_PROT, 8'h00);
        rd(ADDR_PROT, 8'h80);
        WP_N <= 1'b1;
        wr(ADDR_PROT, 8'h02);
        rd(ADDR_PROT, 8'h02);
        chk({7'h00, QUAD_ALLOWED}, 8'h00);
        WP_N <= 1'b0;
        wr(ADDR_CFG, 8'h00);
        rd(ADDR_CFG, 8'h10);
        WP_N <= 1'b1;
        wr(ADDR_PROT, 8'h08);
        rd(ADDR_PROT, 8'h08);
        $display("test write gating done");
        fail_mode <= 1'b1;
        op4(OPC_PROG_EXEC, 24'h3FDDC0);
        rd(ADDR_FLAGS, 8'h08);
        fail_mode <= 1'b0;
        op4(OPC_ERASE, 24'h000000);
        rd(ADDR_FLAGS, 8'h00);
        ecc_val <= ECC_OK_4;
        op4(OPC_PAGE_READ, 24'h000040);
        chk(OP_CMD, OPC_PAGE_READ);
        chk(OP_ROW[7:0], 8'h40);
        rd(ADDR_FLAGS, 8'h10);
        op4(OPC_PROG_EXEC, 24'h03FE00);
        rd(ADDR_FLAGS, 8'h18);
        chk(n_start, 8'h03);
        cmd(OPC_RESET);
        rd(ADDR_FLAGS, 8'h00);
        rd(ADDR_CFG, 8'h10);
        cmd(OPC_WRITE_ENABLE_CMD);
        wr(ADDR_CFG, 8'h50);
        chk({7'h00, OTP_ACCESS}, 8'h01);
        cmd(OPC_RESET);
        rd(ADDR_CFG, 8'h10);
        wr(ADDR_CFG, 8'h90);
        ready();
        wr(ADDR_CFG, 8'h10);
        rd(ADDR_CFG, 8'h90);
        chk({7'h00, OTP_LOCKED}, 8'h01);
        for (int k = 0; k < 4; k++) begin
            cmd(OPC_WRITE_ENABLE_CMD);
            host.xfer({OPC_BBM, 8'h00, 8'h01, 8'h00, 8'h02}, rx);
            ready();
        end
        rd(ADDR_FLAGS, 8'h42);
        chk(OP_CMD, OPC_BBM);
        chk(n_start, 8'h07);
        $display("test operations done");
        cmd(OPC_WRITE_ENABLE_CMD);
        wr(ADDR_PROT, 8'h01);
        wr(ADDR_PROT, 8'h7C);
        rd(ADDR_PROT, 8'h01);
        por();
        cmd(OPC_WRITE_ENABLE_CMD);
        ready();
        rd(ADDR_FLAGS, 8'h00);
        rd(ADDR_PROT, 8'h7C);
        $display("test lock done");
        conclude();
    end
endmodule // nsp_regs_tb
